// ### mdu_pkg.sv
/*
 * constants and types shared by the multiply/divide datapath.
 * assumes a single core clock and an active-low asynchronous reset.
 */
// Function
// - long multiplies treat both sources as unsigned 32-bit integers
// - plain long multiply: low 32 bits to low destination, high to high
// - double accumulate: product plus high value plus low value, split back
// - accumulate long: product plus 64-bit pair, written back to pair
// - long multiplies leave condition flags unchanged
// - halfword selector B picks bits 15:0, T picks 31:16
// - halfword multiply: signed 16x16, full 32-bit product
// - word-by-half multiply: keep upper 32 bits of signed 48-bit product
// - signed divide treats operands as two's complement
// - unsigned divide treats operands as unsigned
// - quotients truncate toward zero
// - without separate destination the quotient goes to the dividend register
// - divides leave condition flags unchanged
package mdu_pkg;
    localparam int unsigned MDU_WIDTH      = 32;
    localparam int unsigned MDU_HALF       = 16;
    localparam int unsigned MDU_CNT_W      = 6;
    localparam logic [5:0]  MDU_DIV_STEPS  = 6'h20;
    localparam logic [31:0] MDU_ZERO32     = 32'h0;

    typedef enum logic [2:0] {
        MDU_OP_UNSIGNED_LONG_MULTIPLY              = 3'h0,
        MDU_OP_UNSIGNED_MULTIPLY_DOUBLE_ACCUMULATE = 3'h1,
        MDU_OP_UNSIGNED_MULTIPLY_ACCUMULATE_LONG   = 3'h2,
        MDU_OP_SIGNED_HALFWORD_MULTIPLY            = 3'h3,
        MDU_OP_SIGNED_WORD_BY_HALF_MULTIPLY        = 3'h4,
        MDU_OP_SIGNED_DIVIDE                       = 3'h5,
        MDU_OP_UNSIGNED_DIVIDE                     = 3'h6
    } mdu_op_t;

    typedef enum logic [1:0] {
        MDU_ST_IDLE = 2'h0,
        MDU_ST_DIV  = 2'h1,
        MDU_ST_DONE = 2'h2
    } mdu_state_t;
endpackage

// ### mdu_div_if.sv
/*
 * carrier between the top and the iterative divider.
 * assumes both ends run on the core clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface mdu_div_if;
    logic        start;
    logic        is_signed;
    logic [31:0] dividend;
    logic [31:0] divisor;
    logic        busy;
    logic        finish;
    logic [31:0] quotient;

    modport ctrl (output start, is_signed, dividend, divisor,
                  input busy, finish, quotient);
    modport unit (input start, is_signed, dividend, divisor,
                  output busy, finish, quotient);
endinterface
`default_nettype wire

// ### mdu_divider.sv
/*
 * restoring shift-subtract divider, one quotient bit per clock.
 * assumes operands are held by the caller while busy.
 */
`timescale 1ns/1ns
`default_nettype none
module mdu_divider
    import mdu_pkg::*;
(
    input  wire logic clk_in,     // core clock
    input  wire logic rst_n_in,   // async reset, active low
    mdu_div_if.unit   div         // request and answer
);
    logic [31:0] rem_reg,  rem_next;
    logic [31:0] quo_reg,  quo_next;
    logic [31:0] dvs_reg,  dvs_next;
    logic [5:0]  cnt_reg,  cnt_next;
    logic        neg_reg,  neg_next;
    logic        busy_reg, busy_next;
    logic        fin_reg,  fin_next;
    logic [32:0] trial;
    logic [31:0] a_mag;
    logic [31:0] b_mag;
    logic [31:0] rem_sh;

    always_comb begin
        rem_next  = rem_reg;
        quo_next  = quo_reg;
        dvs_next  = dvs_reg;
        cnt_next  = cnt_reg;
        neg_next  = neg_reg;
        busy_next = busy_reg;
        fin_next  = 1'b0;
        // magnitudes for signed operation; unsigned passes straight
        a_mag = (div.is_signed && div.dividend[31]) ? 32'(-div.dividend) : div.dividend;
        b_mag = (div.is_signed && div.divisor[31])  ? 32'(-div.divisor)  : div.divisor;
        rem_sh = {rem_reg[30:0], quo_reg[31]};
        trial  = {1'b0, rem_sh} - {1'b0, dvs_reg};
        if (div.start && !busy_reg) begin
            rem_next  = MDU_ZERO32;
            quo_next  = a_mag;
            dvs_next  = b_mag;
            cnt_next  = MDU_DIV_STEPS;
            neg_next  = div.is_signed && (div.dividend[31] ^ div.divisor[31]);
            busy_next = 1'b1;
        end else if (busy_reg) begin
            if (trial[32]) begin
                rem_next = rem_sh;
                quo_next = {quo_reg[30:0], 1'b0};
            end else begin
                rem_next = trial[31:0];
                quo_next = {quo_reg[30:0], 1'b1};
            end
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
                busy_next = 1'b0;
                fin_next  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rem_reg  <= 32'h0;
            quo_reg  <= 32'h0;
            dvs_reg  <= 32'h0;
            cnt_reg  <= 6'h0;
            neg_reg  <= 1'b0;
            busy_reg <= 1'b0;
            fin_reg  <= 1'b0;
        end else begin
            rem_reg  <= rem_next;
            quo_reg  <= quo_next;
            dvs_reg  <= dvs_next;
            cnt_reg  <= cnt_next;
            neg_reg  <= neg_next;
            busy_reg <= busy_next;
            fin_reg  <= fin_next;
        end
    end

    // magnitude division then sign fix truncates toward zero
    // zero divisor: explicit zero rather than the all-ones a raw divide gives
    assign div.quotient = (dvs_reg == 32'h0) ? MDU_ZERO32 :
                          (neg_reg ? 32'(-quo_reg) : quo_reg);
    assign div.busy     = busy_reg;
    assign div.finish   = fin_reg;
endmodule
`default_nettype wire

// ### mdu_datapath.sv
/*
 * multiply/divide execution unit: long unsigned multiplies, signed
 * halfword multiplies and 32-bit divides behind a valid/done handshake.
 * assumes the decode stage holds operands and opcode stable until done,
 * and names legal, distinct registers; no flag outputs exist at all.
 */
`timescale 1ns/1ns
`default_nettype none
module mdu_datapath
    import mdu_pkg::*;
(
    input  wire logic              SYS_CLK_IN,        // core clock, 10 MHz
    input  wire logic              RESET_N_IN,        // async reset, active low
    input  wire logic              OP_VALID_IN,       // request, sampled in idle; a level held past done issues again
    input  wire mdu_pkg::mdu_op_t  OP_CODE_IN,        // operation select
    input  wire logic              SEL_FIRST_TOP_IN,  // first source halfword: 1 = top
    input  wire logic              SEL_SECOND_TOP_IN, // second source halfword: 1 = top
    input  wire logic              DEST_GIVEN_IN,     // divide names its own destination
    input  wire logic [31:0]       FIRST_SOURCE_IN,   // first operand / dividend
    input  wire logic [31:0]       SECOND_SOURCE_IN,  // second operand / divisor
    input  wire logic [31:0]       HIGH_DEST_IN,      // high destination current value
    input  wire logic [31:0]       LOW_DEST_IN,       // low destination current value
    output logic                   DONE_OUT,          // one-cycle result strobe
    output logic [31:0]            RESULT_LO_OUT,     // low / single result
    output logic [31:0]            RESULT_HI_OUT,     // high result of long multiply
    output logic                   WRITE_HI_OUT,      // high result is meaningful
    output logic                   WB_TO_DIVIDEND_OUT // write result into dividend register
);
    import mdu_pkg::*;

    mdu_div_if div_bus ();

    mdu_state_t  state_reg, state_next;
    logic        done_reg,  done_next;
    logic [31:0] lo_reg,    lo_next;
    logic [31:0] hi_reg,    hi_next;
    logic        whi_reg,   whi_next;
    logic        wbd_reg,   wbd_next;
    logic        start_reg, start_next;
    logic        dest_reg,  dest_next;
    logic        sgn_reg,   sgn_next;

    logic [63:0] uprod;
    logic [63:0] long_res;
    logic signed [15:0] half_a;
    logic signed [15:0] half_b;
    logic signed [31:0] half_prod;
    logic signed [47:0] wide_prod;
    logic        is_div;
    logic [31:0] mul_lo;
    logic [31:0] mul_hi;
    logic        mul_whi;
    logic        take;
    logic        take_mul;
    logic        take_div;
    logic        div_done;

    // unsigned product of the full words
    assign uprod = {32'h0, FIRST_SOURCE_IN} * {32'h0, SECOND_SOURCE_IN};

    always_comb begin
        case (OP_CODE_IN)
            MDU_OP_UNSIGNED_MULTIPLY_DOUBLE_ACCUMULATE:
                long_res = uprod + {32'h0, HIGH_DEST_IN} + {32'h0, LOW_DEST_IN};
            MDU_OP_UNSIGNED_MULTIPLY_ACCUMULATE_LONG:
                long_res = uprod + {HIGH_DEST_IN, LOW_DEST_IN};
            default:
                long_res = uprod;
        endcase
    end

    // operand halfword selection
    assign half_a    = SEL_FIRST_TOP_IN  ? FIRST_SOURCE_IN[31:16]  : FIRST_SOURCE_IN[15:0];
    assign half_b    = SEL_SECOND_TOP_IN ? SECOND_SOURCE_IN[31:16] : SECOND_SOURCE_IN[15:0];
    assign half_prod = 32'(half_a) * 32'(half_b);
    assign wide_prod = 48'($signed(FIRST_SOURCE_IN)) * 48'(half_b);

    assign is_div = (OP_CODE_IN == MDU_OP_SIGNED_DIVIDE) ||
                    (OP_CODE_IN == MDU_OP_UNSIGNED_DIVIDE);

    assign div_bus.start     = start_reg;
    assign div_bus.is_signed = sgn_reg;
    assign div_bus.dividend  = FIRST_SOURCE_IN;
    assign div_bus.divisor   = SECOND_SOURCE_IN;

    mdu_divider u_divider (
        .clk_in   (SYS_CLK_IN),
        .rst_n_in (RESET_N_IN),
        .div      (div_bus)
    );

    // pick each multiply's words before the handshake logic sees them
    always_comb begin
        mul_lo  = long_res[31:0];
        mul_hi  = long_res[63:32];
        mul_whi = 1'b1;
        case (OP_CODE_IN)
            MDU_OP_SIGNED_HALFWORD_MULTIPLY: begin
                mul_lo  = half_prod;
                mul_hi  = MDU_ZERO32;
                mul_whi = 1'b0;
            end
            MDU_OP_SIGNED_WORD_BY_HALF_MULTIPLY: begin
                mul_lo  = wide_prod[47:16];
                mul_hi  = MDU_ZERO32;
                mul_whi = 1'b0;
            end
            default: begin
                mul_lo  = long_res[31:0];
                mul_hi  = long_res[63:32];
                mul_whi = 1'b1;
            end
        endcase
    end

    // requests are looked at in idle only, so the done cycle and a running
    // divide refuse them without any extra gating
    assign take     = (state_reg == MDU_ST_IDLE) && OP_VALID_IN;
    assign take_mul = take && !is_div;
    assign take_div = take && is_div;
    assign div_done = (state_reg == MDU_ST_DIV) && div_bus.finish;

    // request group: sign and destination choice are kept from the taking
    // edge, so the far end of a long divide cannot drift with those inputs
    always_comb begin
        dest_next = dest_reg;
        sgn_next  = sgn_reg;
        if (take_div) begin
            dest_next = DEST_GIVEN_IN;
            sgn_next  = (OP_CODE_IN == MDU_OP_SIGNED_DIVIDE);
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            dest_reg <= 1'b0;
            sgn_reg  <= 1'b0;
        end else begin
            dest_reg <= dest_next;
            sgn_reg  <= sgn_next;
        end
    end

    // handshake group: state, done strobe and divider start
    always_comb begin
        state_next = state_reg;
        done_next  = 1'b0;
        start_next = 1'b0;
        case (state_reg)
            MDU_ST_IDLE: begin
                if (take_div) begin
                    // the core keeps operands steady while this runs
                    start_next = 1'b1;
                    state_next = MDU_ST_DIV;
                end else if (take_mul) begin
                    done_next  = 1'b1;
                    state_next = MDU_ST_DONE;
                end
            end
            MDU_ST_DIV: begin
                if (div_done) begin
                    done_next  = 1'b1;
                    state_next = MDU_ST_DONE;
                end
            end
            MDU_ST_DONE: begin
                // one idle cycle lets the core drop or change its request
                state_next = MDU_ST_IDLE;
            end
            default: state_next = MDU_ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_reg <= MDU_ST_IDLE;
            done_reg  <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            done_reg  <= done_next;
            start_reg <= start_next;
        end
    end

    // result group: words and write flags change only with a done, so they
    // stand until the next one
    always_comb begin
        lo_next  = lo_reg;
        hi_next  = hi_reg;
        whi_next = whi_reg;
        wbd_next = wbd_reg;
        if (take_mul) begin
            // single-cycle multiply; flags are never touched
            lo_next  = mul_lo;
            hi_next  = mul_hi;
            whi_next = mul_whi;
            wbd_next = 1'b0;
        end else if (div_done) begin
            // quotient only, flags untouched
            lo_next  = div_bus.quotient;
            hi_next  = MDU_ZERO32;
            whi_next = 1'b0;
            wbd_next = !dest_reg;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            lo_reg  <= MDU_ZERO32;
            hi_reg  <= MDU_ZERO32;
            whi_reg <= 1'b0;
            wbd_reg <= 1'b0;
        end else begin
            lo_reg  <= lo_next;
            hi_reg  <= hi_next;
            whi_reg <= whi_next;
            wbd_reg <= wbd_next;
        end
    end

    assign DONE_OUT           = done_reg;
    assign RESULT_LO_OUT      = lo_reg;
    assign RESULT_HI_OUT      = hi_reg;
    assign WRITE_HI_OUT       = whi_reg;
    assign WB_TO_DIVIDEND_OUT = wbd_reg;
endmodule
`default_nettype wire

// ### mdu_datapath_asserts.sv
/* port checker for the multiply/divide datapath.
   assumes the core holds operands and opcode from take until done. */
`timescale 1ns/1ns
`default_nettype none
module mdu_datapath_asserts
    import mdu_pkg::*;
(
    input wire logic             SYS_CLK_IN,         // core clock
    input wire logic             RESET_N_IN,         // reset, active low
    input wire logic             OP_VALID_IN,        // request
    input wire mdu_pkg::mdu_op_t OP_CODE_IN,         // operation
    input wire logic             SEL_FIRST_TOP_IN,   // first half select
    input wire logic             SEL_SECOND_TOP_IN,  // second half select
    input wire logic             DEST_GIVEN_IN,      // own destination
    input wire logic [31:0]      FIRST_SOURCE_IN,    // first operand
    input wire logic [31:0]      SECOND_SOURCE_IN,   // second operand
    input wire logic [31:0]      HIGH_DEST_IN,       // high value
    input wire logic [31:0]      LOW_DEST_IN,        // low value
    input wire logic             DONE_OUT,           // result strobe
    input wire logic [31:0]      RESULT_LO_OUT,      // low result
    input wire logic [31:0]      RESULT_HI_OUT,      // high result
    input wire logic             WRITE_HI_OUT,       // high result valid
    input wire logic             WB_TO_DIVIDEND_OUT  // write to dividend
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    logic               busy_reg;
    logic               busy_next;
    logic               take;
    logic               is_div;
    logic        [15:0] h1;
    logic        [15:0] h2;
    logic        [31:0] half_p;
    logic        [47:0] wide;
    logic        [31:0] wbh_p;
    logic signed [31:0] sq;
    logic        [31:0] div_q;
    logic        [63:0] prod;
    // the done cycle itself is refused, so it never counts as a take
    assign take = OP_VALID_IN && !busy_reg && !DONE_OUT;
    assign is_div = OP_CODE_IN >= MDU_OP_SIGNED_DIVIDE;
    assign h1 = SEL_FIRST_TOP_IN ? FIRST_SOURCE_IN[31:16] : FIRST_SOURCE_IN[15:0];
    assign h2 = SEL_SECOND_TOP_IN ? SECOND_SOURCE_IN[31:16] : SECOND_SOURCE_IN[15:0];
    assign half_p = $signed(h1) * $signed(h2);
    assign wide = $signed(FIRST_SOURCE_IN) * $signed(h2);
    assign wbh_p = wide[47:16];
    assign prod = {32'h0, FIRST_SOURCE_IN} * {32'h0, SECOND_SOURCE_IN};
    assign sq = $signed(FIRST_SOURCE_IN) / $signed(SECOND_SOURCE_IN);
    assign div_q = (SECOND_SOURCE_IN == 32'h0) ? 32'h0 :
                   (OP_CODE_IN == MDU_OP_SIGNED_DIVIDE) ? sq :
                   FIRST_SOURCE_IN / SECOND_SOURCE_IN;
    always_comb busy_next = take ? 1'b1 : (DONE_OUT ? 1'b0 : busy_reg);
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) busy_reg <= 1'b0;
        else busy_reg <= busy_next;
    end
    done_pulse_a: assert property (DONE_OUT |=> !DONE_OUT)
        else $error("done held past one cycle");
    mul_latency_a: assert property (take && !is_div |=> DONE_OUT)
        else $error("multiply done late");
    div_latency_a: assert property (take && is_div |-> ##35 DONE_OUT)
        else $error("divide done not at cycle 35");
    long_mul_a: assert property (take && OP_CODE_IN == MDU_OP_UNSIGNED_LONG_MULTIPLY
        |=> {RESULT_HI_OUT, RESULT_LO_OUT} == $past(prod) && WRITE_HI_OUT)
        else $error("long product wrong");
    dbl_acc_a: assert property (take && OP_CODE_IN == MDU_OP_UNSIGNED_MULTIPLY_DOUBLE_ACCUMULATE
        |=> {RESULT_HI_OUT, RESULT_LO_OUT} == $past(prod + HIGH_DEST_IN + LOW_DEST_IN))
        else $error("double accumulate wrong");
    acc_long_a: assert property (take && OP_CODE_IN == MDU_OP_UNSIGNED_MULTIPLY_ACCUMULATE_LONG
        |=> {RESULT_HI_OUT, RESULT_LO_OUT} == $past(prod + {HIGH_DEST_IN, LOW_DEST_IN}))
        else $error("accumulate long wrong");
    half_mul_a: assert property (take && OP_CODE_IN == MDU_OP_SIGNED_HALFWORD_MULTIPLY
        |=> RESULT_LO_OUT == $past(half_p))
        else $error("halfword product wrong");
    word_half_a: assert property (take && OP_CODE_IN == MDU_OP_SIGNED_WORD_BY_HALF_MULTIPLY
        |=> RESULT_LO_OUT == $past(wbh_p))
        else $error("word by half product wrong");
    div_quot_a: assert property (take && is_div |-> ##35 RESULT_LO_OUT == div_q)
        else $error("quotient wrong");
    div_wb_a: assert property (take && is_div |-> ##35 WB_TO_DIVIDEND_OUT == !DEST_GIVEN_IN)
        else $error("dividend write back wrong");
    cover property (take && OP_CODE_IN == MDU_OP_UNSIGNED_LONG_MULTIPLY);
    cover property (take && OP_CODE_IN == MDU_OP_SIGNED_HALFWORD_MULTIPLY);
    cover property (take && is_div && SECOND_SOURCE_IN == 32'h0);
endmodule
`default_nettype wire

// ### mdu_core_model.sv
/* decode and register file stand-in: issues one operation, holds it to done.
   assumes a one-cycle done strobe from the datapath. */
`timescale 1ns/1ns
`default_nettype none
module mdu_core_model
    import mdu_pkg::*;
(
    input  wire logic        clk_in,    // core clock
    input  wire logic        done_in,   // result strobe
    output mdu_pkg::mdu_op_t op_out,    // operation
    output logic             valid_out, // request
    output logic             sel1_out,  // first half top
    output logic             sel2_out,  // second half top
    output logic             dest_out,  // own destination
    output logic [31:0]      a_out,     // first source
    output logic [31:0]      b_out,     // second source
    output logic [31:0]      hi_out,    // high value
    output logic [31:0]      lo_out     // low value
);
    int lat;
    initial begin
        valid_out = 1'b0;
        op_out = MDU_OP_UNSIGNED_LONG_MULTIPLY;
        {sel1_out, sel2_out, dest_out} = 3'h0;
        {a_out, b_out, hi_out, lo_out} = 128'h0;
    end
    // callers only pass distinct, legal register contents
    task automatic issue(input mdu_op_t op, input logic [31:0] a, b, h, l,
                         input logic s1, s2, dg);
        int n;
        @(posedge clk_in);
        op_out <= op;
        {sel1_out, sel2_out, dest_out} <= {s1, s2, dg};
        {a_out, b_out, hi_out, lo_out} <= {a, b, h, l};
        valid_out <= 1'b1;
        for (n = 1; n < 60; n++) begin
            @(posedge clk_in);
            if (done_in === 1'b1)
                break;
        end
        lat = n;
        valid_out <= 1'b0;
        // released operands show inverted values so stale data cannot pass
        {a_out, b_out, hi_out, lo_out} <= ~{a, b, h, l};
    endtask
endmodule
`default_nettype wire

// ### mdu_datapath_bench.sv
/* self-checking bench for the multiply/divide datapath.
   assumes the core model and the checker are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
module mdu_datapath_bench;
    import mdu_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        done;
    logic        whi;
    logic        wbd;
    logic        vld;
    logic        s1;
    logic        s2;
    logic        dg;
    logic [31:0] rlo;
    logic [31:0] rhi;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] h;
    logic [31:0] l;
    mdu_op_t     op;
    int          num_errors = 0;
    int          checked = 0;
    mdu_datapath u_dut (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .OP_VALID_IN(vld),
        .OP_CODE_IN(op), .SEL_FIRST_TOP_IN(s1), .SEL_SECOND_TOP_IN(s2), .DEST_GIVEN_IN(dg),
        .FIRST_SOURCE_IN(a), .SECOND_SOURCE_IN(b), .HIGH_DEST_IN(h), .LOW_DEST_IN(l),
        .DONE_OUT(done), .RESULT_LO_OUT(rlo), .RESULT_HI_OUT(rhi), .WRITE_HI_OUT(whi),
        .WB_TO_DIVIDEND_OUT(wbd));
    mdu_core_model u_core (.clk_in(clk), .done_in(done), .op_out(op), .valid_out(vld),
        .sel1_out(s1), .sel2_out(s2), .dest_out(dg), .a_out(a), .b_out(b), .hi_out(h),
        .lo_out(l));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic results;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input mdu_op_t o, input logic [31:0] x, y, hv, lv,
                       input logic t1, t2, d, input logic [63:0] lat);
        u_core.issue(o, x, y, hv, lv, t1, t2, d);
        check(64'(u_core.lat), lat);
        if (u_core.lat >= 60) begin
            num_errors++;
            results();
        end
    endtask
    task automatic t_long;
        run(MDU_OP_UNSIGNED_LONG_MULTIPLY, 32'hffffffff, 32'hfffffffe, 32'h1, 32'h2,
            1'b0, 1'b0, 1'b1, 64'h2);
        check({rhi, rlo}, 64'hffffffff * 64'hfffffffe);
        check(64'(whi), 64'h1);
        $display("long multiply test over");
    endtask
    task automatic t_accum;
        run(MDU_OP_UNSIGNED_MULTIPLY_DOUBLE_ACCUMULATE, 32'hffffffff, 32'hffffffff,
            32'hffffffff, 32'hffffffff, 1'b0, 1'b0, 1'b1, 64'h2);
        check({rhi, rlo}, 64'hffffffffffffffff);
        run(MDU_OP_UNSIGNED_MULTIPLY_ACCUMULATE_LONG, 32'h80000001, 32'h3, 32'h1,
            32'hffffffff, 1'b0, 1'b0, 1'b1, 64'h2);
        check({rhi, rlo}, 64'h80000001 * 64'h3 + 64'h1ffffffff);
        $display("accumulate test over");
    endtask
    task automatic t_half;
        logic [15:0] p;
        logic [15:0] q;
        logic [31:0] e;
        logic [47:0] w;
        for (int i = 0; i < 4; i++) begin
            run(MDU_OP_SIGNED_HALFWORD_MULTIPLY, 32'h80007fff, 32'hfffe0003, 32'h0, 32'h0,
                i[1], i[0], 1'b1, 64'h2);
            p = i[1] ? 16'h8000 : 16'h7fff;
            q = i[0] ? 16'hfffe : 16'h0003;
            e = $signed(p) * $signed(q);
            check(64'(rlo), 64'(e));
            check({31'h0, whi, rhi}, 64'h0);
        end
        for (int i = 0; i < 2; i++) begin
            run(MDU_OP_SIGNED_WORD_BY_HALF_MULTIPLY, 32'h80000001, 32'h7ffffffd, 32'h0,
                32'h0, 1'b1, i[0], 1'b1, 64'h2);
            q = i[0] ? 16'h7fff : 16'hfffd;
            w = $signed(32'h80000001) * $signed(q);
            check(64'(rlo), 64'(w[47:16]));
            check({31'h0, whi, rhi}, 64'h0);
        end
        $display("signed multiply test over");
    endtask
    task automatic t_div;
        logic [31:0] xs [6] = '{32'hfffffff9, 32'hfffffff9, 32'h7, 32'h64,
                                32'h80000000, 32'h80000000};
        logic [31:0] ys [6] = '{32'h2, 32'h2, 32'hfffffffe, 32'h0, 32'h0, 32'h3};
        logic [31:0] e;
        mdu_op_t     o;
        for (int i = 0; i < 6; i++) begin
            o = i[0] ? MDU_OP_UNSIGNED_DIVIDE : MDU_OP_SIGNED_DIVIDE;
            run(o, xs[i], ys[i], 32'h0, 32'h0, 1'b0, 1'b0, i[1], 64'd36);
            if (ys[i] == 32'h0) e = 32'h0;
            else if (!i[0]) e = $signed(xs[i]) / $signed(ys[i]);
            else e = xs[i] / ys[i];
            check(64'(rlo), 64'(e));
            check(64'(wbd), 64'(!i[1]));
            check({31'h0, whi, rhi}, 64'h0);
        end
        $display("divide test over");
    endtask
    task automatic t_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check({rhi, rlo}, 64'h0);
        check(64'({done, whi, wbd}), 64'h0);
        rst_n <= 1'b1;
        run(MDU_OP_UNSIGNED_LONG_MULTIPLY, 32'h00010000, 32'h00030000, 32'h0, 32'h0,
            1'b0, 1'b0, 1'b1, 64'h2);
        check({rhi, rlo}, 64'h0000000300000000);
        $display("reset test over");
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_long();
        t_accum();
        t_half();
        t_div();
        t_reset();
        results();
    end
endmodule
bind mdu_datapath mdu_datapath_asserts u_chk (
    .SYS_CLK_IN         (SYS_CLK_IN),
    .RESET_N_IN         (RESET_N_IN),
    .OP_VALID_IN        (OP_VALID_IN),
    .OP_CODE_IN         (OP_CODE_IN),
    .SEL_FIRST_TOP_IN   (SEL_FIRST_TOP_IN),
    .SEL_SECOND_TOP_IN  (SEL_SECOND_TOP_IN),
    .DEST_GIVEN_IN      (DEST_GIVEN_IN),
    .FIRST_SOURCE_IN    (FIRST_SOURCE_IN),
    .SECOND_SOURCE_IN   (SECOND_SOURCE_IN),
    .HIGH_DEST_IN       (HIGH_DEST_IN),
    .LOW_DEST_IN        (LOW_DEST_IN),
    .DONE_OUT           (DONE_OUT),
    .RESULT_LO_OUT      (RESULT_LO_OUT),
    .RESULT_HI_OUT      (RESULT_HI_OUT),
    .WRITE_HI_OUT       (WRITE_HI_OUT),
    .WB_TO_DIVIDEND_OUT (WB_TO_DIVIDEND_OUT)
);
`default_nettype wire
